// [verilog/usbcp_pkg.sv]
package usbcp_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ADDR_ENABLE  = 8'hD0;
  localparam logic [7:0] CMD_EP_ENABLE    = 8'hD8;
  localparam logic [7:0] CMD_SET_MODE     = 8'hF3;
  localparam logic [7:0] CMD_READ_IRQ     = 8'hF4;
  localparam logic [7:0] CMD_SELECT_BASE  = 8'h00;
  localparam logic [7:0] CMD_STATUS_BASE  = 8'h40;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ADDR_ENABLE_BIT  = 7;
  localparam int EP_ENABLE_BIT    = 0;
  localparam int BUF_FULL_BIT     = 0;
  localparam int STALL_BIT        = 0;
  localparam int MODE_SINK_USE    = 0;
  localparam int MODE_SOURCE_USE  = 1;
  localparam int MODE_SINK_IRQ    = 2;
  localparam int MODE_SOURCE_IRQ  = 3;
  localparam int MODE_DIAG        = 4;
  localparam int MODE_KEEP_CLK    = 5;

  // ----------------------------------------------------------------
  // values after reset and bus reset behaviour of the mode byte
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_RESET       = 7'h00;
  localparam logic [7:0] MODE_RESET       = 8'h00;
  localparam logic [7:0] MODE_USED_MASK   = 8'h3F;
  localparam logic [7:0] MODE_BUSRST_MASK = 8'h0F;

  // ----------------------------------------------------------------
  // endpoint map and timing
  // ----------------------------------------------------------------
  localparam int EP_IDX_W         = 3;
  localparam int EP_DEFAULT_COUNT = 2;
  localparam int EP_SINK_STREAM   = 4;
  localparam int EP_SOURCE_STREAM = 5;
  localparam int ACTION_CYCLES    = 2;

  typedef enum logic [0:0] {
    st_idle,
    st_busy
  } usbcp_state_e;

  typedef enum logic [1:0] {
    act_cmd,
    act_wr,
    act_rd
  } usbcp_act_e;

endpackage

// [verilog/usbcp_endpoint.sv]
module usbcp_endpoint
  import usbcp_pkg::*;
#(
  parameter bit IS_CONTROL = 1'b0,
  parameter bit IS_IN      = 1'b0
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // engine events
  input  wire logic       bus_reset,
  input  wire logic       ev_hit,
  input  wire logic       ev_success,
  input  wire logic [3:0] ev_error,
  input  wire logic       ev_setup,
  input  wire logic       ev_data1,
  input  wire logic       irq_allow,
  input  wire logic       setup_token,
  // command side
  input  wire logic       status_read,
  input  wire logic       stall_wr,
  input  wire logic       stall_val,
  // state out
  output logic            flag,
  output logic [7:0]      status,
  output logic            stalled,
  output logic            reinit
);

  logic [6:0] body;
  logic       unread;
  logic       prev_lost;
  logic       next_stalled;

  assign status = {prev_lost, body};

  // last transaction status; an in buffer never reports a setup
  always_ff @(posedge mclk) begin
    if (srst) begin
      body <= 7'h00;
    end else if (ev_hit) begin
      body <= {ev_data1, ev_setup & ~IS_IN, ev_error, ev_success};
    end
  end

  // unread tracking; a new event in the read cycle stays unread
  always_ff @(posedge mclk) begin
    if (srst) begin
      unread    <= 1'b0;
      prev_lost <= 1'b0;
    end else begin
      if (ev_hit) begin
        unread <= 1'b1;
      end else if (status_read) begin
        unread <= 1'b0;
      end
      if (ev_hit && unread && !status_read) begin
        prev_lost <= 1'b1;
      end else if (status_read) begin
        prev_lost <= 1'b0;
      end
    end
  end

  // interrupt flag: the set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      flag <= 1'b0;
    end else if (ev_hit && irq_allow) begin
      flag <= 1'b1;
    end else if (status_read || bus_reset) begin
      flag <= 1'b0;
    end
  end

  // stall control and self unstall of control endpoints on setup
  always_comb begin
    next_stalled = stalled;
    if (stall_wr) begin
      next_stalled = stall_val;
    end else if (setup_token && IS_CONTROL) begin
      next_stalled = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stalled <= 1'b0;
      reinit  <= 1'b0;
    end else begin
      stalled <= next_stalled;
      reinit  <= stalled & ~next_stalled;
    end
  end

endmodule

// [verilog/usbcp_top.sv]
module usbcp_top
  import usbcp_pkg::*;
#(
  parameter int NEP = 6
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                srst,
  // controller command and data port
  input  wire logic                cmd_wr,
  input  wire logic                data_wr,
  input  wire logic                data_rd,
  input  wire logic [7:0]          wdata,
  output logic [7:0]               rdata,
  output logic                     action_done_flag,
  output logic                     engine_irq_out,
  // protocol engine events
  input  wire logic                bus_reset,
  input  wire logic                ev_valid,
  input  wire logic [EP_IDX_W-1:0] ev_ep,
  input  wire logic                ev_success,
  input  wire logic [3:0]          ev_error,
  input  wire logic                ev_setup,
  input  wire logic                ev_data1,
  input  wire logic                setup_token,
  input  wire logic [NEP-1:0]      buf_full,
  // configuration to the protocol engine
  output logic [6:0]               dev_addr,
  output logic                     func_enable,
  output logic                     nondef_ep_enable,
  output logic                     sink_stream_usable,
  output logic                     source_stream_usable,
  output logic                     sink_stream_irq_allow,
  output logic                     source_stream_irq_allow,
  output logic                     diagnostic_mode,
  output logic                     keep_synth_clock_running,
  // endpoint control to the protocol engine
  output logic [NEP-1:0]           ep_stalled,
  output logic [NEP-1:0]           ep_reinit,
  output logic [EP_IDX_W-1:0]      sel_ep,
  output logic                     buf_ptr_reset
);

  // ----------------------------------------------------------------
  // action sequencer
  // ----------------------------------------------------------------
  usbcp_state_e         state;
  usbcp_act_e           act;
  logic [1:0]           cnt;
  logic [7:0]           held;
  logic                 take;
  logic                 finish;

  assign take   = (state == st_idle) && (cmd_wr || data_wr || data_rd);
  assign finish = (state == st_busy) && (cnt == 2'd0);

  // requests while busy are dropped; the controller must pace on ready
  always_ff @(posedge mclk) begin
    if (srst) begin
      state            <= st_idle;
      act              <= act_cmd;
      cnt              <= 2'd0;
      held             <= 8'h00;
      action_done_flag <= 1'b1;
    end else begin
      case (state)
        st_idle: begin
          if (take) begin
            if (cmd_wr) begin
              act <= act_cmd;
            end else if (data_wr) begin
              act <= act_wr;
            end else begin
              act <= act_rd;
            end
            held             <= wdata;
            cnt              <= 2'(ACTION_CYCLES - 1);
            action_done_flag <= 1'b0;
            state            <= st_busy;
          end
        end
        st_busy: begin
          if (cnt == 2'd0) begin
            action_done_flag <= 1'b1;
            state            <= st_idle;
          end else begin
            cnt <= cnt - 2'd1;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command holding and decode
  // ----------------------------------------------------------------
  logic [7:0]           cmd_code;
  logic                 cmd_open;
  logic                 do_cmd;
  logic                 do_wr;
  logic                 do_rd;
  logic                 sel_hit;
  logic                 stat_hit;
  logic [EP_IDX_W-1:0]  cmd_ep;

  // the first data cycle consumes the command; later cycles are void
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd_code <= 8'h00;
      cmd_open <= 1'b0;
    end else if (finish && act == act_cmd) begin
      cmd_code <= held;
      cmd_open <= 1'b1;
    end else if (finish) begin
      cmd_open <= 1'b0;
    end
  end

  assign do_cmd   = finish && (act == act_cmd);
  assign do_wr    = finish && (act == act_wr) && cmd_open;
  assign do_rd    = finish && (act == act_rd) && cmd_open;
  assign sel_hit  = (cmd_code >= CMD_SELECT_BASE) && (cmd_code < CMD_SELECT_BASE + 8'(NEP));
  assign stat_hit = (cmd_code >= CMD_STATUS_BASE) && (cmd_code < CMD_STATUS_BASE + 8'(NEP));
  assign cmd_ep   = cmd_code[EP_IDX_W-1:0];

  // select endpoint acts at the command itself, the read is optional
  always_ff @(posedge mclk) begin
    if (srst) begin
      sel_ep        <= '0;
      buf_ptr_reset <= 1'b0;
    end else begin
      buf_ptr_reset <= 1'b0;
      if (do_cmd && (held >= CMD_SELECT_BASE) && (held < CMD_SELECT_BASE + 8'(NEP))) begin
        sel_ep        <= held[EP_IDX_W-1:0];
        buf_ptr_reset <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // device configuration registers
  // ----------------------------------------------------------------
  logic [7:0]           mode;

  // address and enable; disabled from power-up and after bus reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      dev_addr    <= ADDR_RESET;
      func_enable <= 1'b0;
    end else if (bus_reset) begin
      dev_addr    <= ADDR_RESET;
      func_enable <= 1'b0;
    end else if (do_wr && cmd_code == CMD_ADDR_ENABLE) begin
      dev_addr    <= held[6:0];
      func_enable <= held[ADDR_ENABLE_BIT];
    end
  end

  // non-default endpoint enable
  always_ff @(posedge mclk) begin
    if (srst) begin
      nondef_ep_enable <= 1'b0;
    end else if (bus_reset) begin
      nondef_ep_enable <= 1'b0;
    end else if (do_wr && cmd_code == CMD_EP_ENABLE) begin
      nondef_ep_enable <= held[EP_ENABLE_BIT];
    end
  end

  // mode byte; only the sensitive bits fall back on bus reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode <= MODE_RESET;
    end else if (bus_reset) begin
      mode <= (mode & ~MODE_BUSRST_MASK) | (MODE_RESET & MODE_BUSRST_MASK);
    end else if (do_wr && cmd_code == CMD_SET_MODE) begin
      mode <= held & MODE_USED_MASK;
    end
  end

  assign sink_stream_usable       = mode[MODE_SINK_USE];
  assign source_stream_usable     = mode[MODE_SOURCE_USE];
  assign sink_stream_irq_allow    = mode[MODE_SINK_IRQ];
  assign source_stream_irq_allow  = mode[MODE_SOURCE_IRQ];
  assign diagnostic_mode          = mode[MODE_DIAG];
  assign keep_synth_clock_running = mode[MODE_KEEP_CLK];

  // ----------------------------------------------------------------
  // endpoints
  // ----------------------------------------------------------------
  logic [NEP-1:0]       ep_flag;
  logic [7:0]           ep_status [NEP];
  logic [NEP-1:0]       ep_hit;
  logic [NEP-1:0]       ep_allow;
  logic [NEP-1:0]       ep_read;
  logic [NEP-1:0]       ep_stall_wr;

  // events are accepted only for endpoints the host may talk to
  always_comb begin
    for (int i = 0; i < NEP; i++) begin
      ep_hit[i]      = ev_valid && func_enable && (ev_ep == EP_IDX_W'(i))
                       && (i < EP_DEFAULT_COUNT || nondef_ep_enable);
      ep_allow[i]    = 1'b1;
      ep_read[i]     = do_rd && stat_hit && (cmd_ep == EP_IDX_W'(i));
      ep_stall_wr[i] = do_wr && stat_hit && (cmd_ep == EP_IDX_W'(i));
    end
    // stream endpoints raise a flag only when the mode allows it
    ep_allow[EP_SINK_STREAM]   = sink_stream_irq_allow;
    ep_allow[EP_SOURCE_STREAM] = source_stream_irq_allow;
  end

  // even indices face out, odd ones in; the first pair is control
  for (genvar g = 0; g < NEP; g++) begin : g_ep
    usbcp_endpoint #(
      .IS_CONTROL (g < EP_DEFAULT_COUNT),
      .IS_IN      (g % 2 == 1)
    ) u_ep (
      .mclk        (mclk),
      .srst        (srst),
      .bus_reset   (bus_reset),
      .ev_hit      (ep_hit[g]),
      .ev_success  (ev_success),
      .ev_error    (ev_error),
      .ev_setup    (ev_setup),
      .ev_data1    (ev_data1),
      .irq_allow   (ep_allow[g]),
      .setup_token (setup_token),
      .status_read (ep_read[g]),
      .stall_wr    (ep_stall_wr[g]),
      .stall_val   (held[STALL_BIT]),
      .flag        (ep_flag[g]),
      .status      (ep_status[g]),
      .stalled     (ep_stalled[g]),
      .reinit      (ep_reinit[g])
    );
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  logic                 reset_irq;

  // bus reset raises the line with an empty register; the set wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      reset_irq <= 1'b0;
    end else if (bus_reset) begin
      reset_irq <= 1'b1;
    end else if (do_rd && cmd_code == CMD_READ_IRQ) begin
      reset_irq <= 1'b0;
    end
  end

  // one cycle behind the flags, which keeps the output a plain flop
  always_ff @(posedge mclk) begin
    if (srst) begin
      engine_irq_out <= 1'b0;
    end else begin
      engine_irq_out <= (|ep_flag) | reset_irq;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0]           next_rdata;

  // unknown codes and void cycles read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (cmd_code == CMD_ADDR_ENABLE) begin
      next_rdata = {func_enable, dev_addr};
    end else if (cmd_code == CMD_EP_ENABLE) begin
      next_rdata[EP_ENABLE_BIT] = nondef_ep_enable;
    end else if (cmd_code == CMD_READ_IRQ) begin
      next_rdata = 8'(ep_flag);
    end else if (sel_hit) begin
      next_rdata[BUF_FULL_BIT] = buf_full[cmd_ep];
    end else if (stat_hit) begin
      next_rdata = ep_status[cmd_ep];
    end
  end

  // data is loaded in the cycle ready rises and held until the next read
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (do_rd) begin
      rdata <= next_rdata;
    end else if (finish && act == act_rd) begin
      rdata <= 8'h00;
    end
  end

endmodule

// [bench/usbcp_checker_asserts.sv]
module usbcp_checker
  import usbcp_pkg::*;
#(
  parameter int NEP = 6
) (
  // clock, reset and controller port
  input wire logic                mclk,
  input wire logic                srst,
  input wire logic                cmd_wr,
  input wire logic                data_wr,
  input wire logic                data_rd,
  input wire logic [7:0]          wdata,
  input wire logic                action_done_flag,
  input wire logic                engine_irq_out,
  // engine events
  input wire logic                bus_reset,
  input wire logic                ev_valid,
  input wire logic [EP_IDX_W-1:0] ev_ep,
  input wire logic                setup_token,
  // configuration and endpoint control
  input wire logic [6:0]          dev_addr,
  input wire logic                func_enable,
  input wire logic                nondef_ep_enable,
  input wire logic                sink_stream_usable,
  input wire logic                diagnostic_mode,
  input wire logic                keep_synth_clock_running,
  input wire logic [NEP-1:0]      ep_stalled,
  input wire logic [NEP-1:0]      ep_reinit,
  input wire logic                buf_ptr_reset
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // ------------------------------------------------------------
  // action handshake
  // ------------------------------------------------------------
  sequence take_s;
    action_done_flag && (cmd_wr || data_wr || data_rd);
  endsequence
  sequence busy_s;
    !action_done_flag [*2] ##1 action_done_flag;
  endsequence
  // a quiet port: a bus reset here cannot race a config update
  sequence quiet_s;
    action_done_flag && !(cmd_wr || data_wr || data_rd);
  endsequence

  take_busy_a: assert property (take_s |=> busy_s)
    else $error("ready did not follow the two cycle action");
  busrst_irq_a: assert property (bus_reset |-> ##[1:3] engine_irq_out)
    else $error("bus reset raised no interrupt");
  event_irq_a: assert property (ev_valid && func_enable && ev_ep < 3'd2 && !bus_reset
    |-> ##2 engine_irq_out)
    else $error("endpoint event raised no interrupt");
  powerup_off_a: assert property ($fell(srst)
    |-> !func_enable && dev_addr == ADDR_RESET && !nondef_ep_enable)
    else $error("function not disabled after reset");
  busrst_clear_a: assert property ((bus_reset and quiet_s)
    |=> !nondef_ep_enable && !func_enable)
    else $error("bus reset left endpoints enabled");
  mode_keep_a: assert property ((bus_reset and quiet_s)
    |=> !sink_stream_usable && $stable(diagnostic_mode) && $stable(keep_synth_clock_running))
    else $error("mode bits wrong after bus reset");
  unstall_reinit_a: assert property (|($past(ep_stalled) & ~ep_stalled) |-> ##[0:1] |ep_reinit)
    else $error("unstall gave no reinit pulse");
  setup_unstall_a: assert property (setup_token && action_done_flag && |ep_stalled[1:0]
    |=> ep_stalled[1:0] == 2'b00)
    else $error("setup token left control endpoint stalled");
  select_ptr_a: assert property ((take_s and (cmd_wr && wdata[7:3] == 5'h00 && wdata[2:0] < 3'(NEP)))
    |-> ##[3:4] buf_ptr_reset)
    else $error("select gave no pointer reset");
endmodule

bind usbcp_top usbcp_checker #(.NEP(NEP)) u_chk (
  .mclk(mclk), .srst(srst), .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata),
  .action_done_flag(action_done_flag), .engine_irq_out(engine_irq_out), .bus_reset(bus_reset),
  .ev_valid(ev_valid), .ev_ep(ev_ep), .setup_token(setup_token), .dev_addr(dev_addr),
  .func_enable(func_enable), .nondef_ep_enable(nondef_ep_enable), .sink_stream_usable(sink_stream_usable),
  .diagnostic_mode(diagnostic_mode), .keep_synth_clock_running(keep_synth_clock_running),
  .ep_stalled(ep_stalled), .ep_reinit(ep_reinit), .buf_ptr_reset(buf_ptr_reset)
);

// [bench/usbcp_ctrl_model.sv]
module usbcp_ctrl_model (
  // clock and answer
  input  wire logic       mclk,
  input  wire logic       action_done_flag,
  input  wire logic [7:0] rdata,
  // requests
  output logic            cmd_wr,
  output logic            data_wr,
  output logic            data_rd,
  output logic [7:0]      wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port at time zero
  initial begin
    cmd_wr  = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    wdata   = 8'h00;
  end

  // kind 0 command, 1 data write, 2 data read; every call ends in ready
  // a hang is left to the bench watchdog, which counts it as a mismatch
  task automatic act(input int kind, input logic [7:0] b, output logic [7:0] r);
    @(posedge mclk);
    cmd_wr  <= (kind == 0);
    data_wr <= (kind == 1);
    data_rd <= (kind == 2);
    wdata   <= b;
    @(posedge mclk);
    cmd_wr  <= 1'b0;
    data_wr <= 1'b0;
    data_rd <= 1'b0;
    wdata   <= ~b; // released bus must not keep the old byte
    do begin
      @(posedge mclk);
      #1;
    end while (action_done_flag !== 1'b1);
    r = rdata;
  endtask
endmodule

// [bench/tb_top.sv]
module tb_top
  import usbcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int NEP = 6;
  logic [7:0]          wdata, rdata, r, s;
  logic                mclk, srst, cmd_wr, data_wr, data_rd, action_done_flag, engine_irq_out;
  logic                bus_reset, ev_valid, ev_success, ev_setup, ev_data1, setup_token;
  logic [EP_IDX_W-1:0] ev_ep, sel_ep;
  logic [3:0]          ev_error;
  logic [NEP-1:0]      buf_full, ep_stalled, ep_reinit;
  logic [6:0]          dev_addr;
  logic                func_enable, nondef_ep_enable, buf_ptr_reset, m0, m1, m2, m3, m4, m5;
  int                  mismatches, comparisons;

  usbcp_top #(.NEP(NEP)) dut (
    .mclk(mclk), .srst(srst), .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata),
    .rdata(rdata), .action_done_flag(action_done_flag), .engine_irq_out(engine_irq_out),
    .bus_reset(bus_reset), .ev_valid(ev_valid), .ev_ep(ev_ep), .ev_success(ev_success),
    .ev_error(ev_error), .ev_setup(ev_setup), .ev_data1(ev_data1), .setup_token(setup_token),
    .buf_full(buf_full), .dev_addr(dev_addr), .func_enable(func_enable), .nondef_ep_enable(nondef_ep_enable),
    .sink_stream_usable(m0), .source_stream_usable(m1), .sink_stream_irq_allow(m2),
    .source_stream_irq_allow(m3), .diagnostic_mode(m4), .keep_synth_clock_running(m5),
    .ep_stalled(ep_stalled), .ep_reinit(ep_reinit), .sel_ep(sel_ep), .buf_ptr_reset(buf_ptr_reset)
  );

  usbcp_ctrl_model ctl (
    .mclk(mclk), .action_done_flag(action_done_flag), .rdata(rdata),
    .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  always #2 mclk = ~mclk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    ctl.act(0, c, r);
    ctl.act(1, d, r);
  endtask

  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    ctl.act(0, c, r);
    ctl.act(2, 8'h00, d);
  endtask

  // one finished transaction; interrupt is settled two edges later
  task automatic ev(input int ep, input logic [3:0] e, input logic su, input logic d1);
    @(posedge mclk);
    ev_valid   <= 1'b1;
    ev_ep      <= ep[EP_IDX_W-1:0];
    ev_error   <= e;
    ev_success <= (e == 4'h0);
    ev_setup   <= su;
    ev_data1   <= d1;
    @(posedge mclk);
    ev_valid   <= 1'b0;
    ev_error   <= ~e;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  function automatic logic [7:0] mode();
    return {2'b00, m5, m4, m3, m2, m1, m0};
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_addr();
    check({action_done_flag, engine_irq_out, func_enable, 5'h00}, 8'h80);
    check({1'b0, dev_addr}, 8'h00);
    wr(CMD_ADDR_ENABLE, 8'h85);
    check({func_enable, dev_addr}, 8'h85);
    rd(CMD_ADDR_ENABLE, s);
    check(s, 8'h85);
    wr(CMD_EP_ENABLE, 8'h01);
    rd(CMD_EP_ENABLE, s);
    check(s, 8'h01);
    check({7'h00, nondef_ep_enable}, 8'h01);
    $display("test addr done");
  endtask

  task automatic t_mode();
    wr(CMD_SET_MODE, 8'h3F);
    check(mode(), 8'h3F);
    @(posedge mclk);
    bus_reset <= 1'b1;
    @(posedge mclk);
    bus_reset <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check(mode(), 8'h30);
    check({func_enable, nondef_ep_enable, engine_irq_out}, 8'h01);
    rd(CMD_READ_IRQ, s);
    check(s, 8'h00);
    // the interrupt output trails the cleared pending bit by one cycle
    @(posedge mclk);
    #1;
    check({7'h00, engine_irq_out}, 8'h00);
    $display("test mode done");
  endtask

  task automatic t_events();
    int ep;
    wr(CMD_ADDR_ENABLE, 8'h80);
    wr(CMD_EP_ENABLE, 8'h01);
    wr(CMD_SET_MODE, 8'h0F);
    for (int c = 0; c < 16; c++) begin
      ep = c % NEP;
      ev(ep, c[3:0], 1'b1, c[0]);
      check({7'h00, engine_irq_out}, 8'h01);
      rd(CMD_READ_IRQ, s);
      check(s, 8'h01 << ep);
      rd(CMD_STATUS_BASE + ep[7:0], s);
      check(s, {1'b0, c[0], ~ep[0], c[3:0], c == 0});
      rd(CMD_READ_IRQ, s);
      check(s, 8'h00);
      check({7'h00, engine_irq_out}, 8'h00);
    end
    ev(2, 4'h9, 1'b0, 1'b0);
    ev(2, 4'h9, 1'b0, 1'b1);
    rd(CMD_STATUS_BASE + 8'h02, s);
    check(s, 8'hD2);
    $display("test events done");
  endtask

  task automatic t_select();
    @(posedge mclk);
    buf_full <= 6'h29;
    for (int k = 0; k < NEP; k++) begin
      rd(CMD_SELECT_BASE + k[7:0], s);
      check(s, {7'h00, buf_full[k]});
      check({5'h00, sel_ep}, k[7:0]);
    end
    $display("test select done");
  endtask

  task automatic t_stall();
    logic seen;
    wr(CMD_STATUS_BASE, 8'h01);
    wr(CMD_STATUS_BASE + 8'h01, 8'h01);
    wr(CMD_STATUS_BASE + 8'h02, 8'hFE);
    check({2'b00, ep_stalled}, 8'h03);
    wr(CMD_STATUS_BASE + 8'h03, 8'h01);
    wr(CMD_STATUS_BASE + 8'h03, 8'h00);
    check({2'b00, ep_stalled}, 8'h03);
    @(posedge mclk);
    setup_token <= 1'b1;
    seen = 1'b0;
    // the reinit pulse stands only in the cycle after the token is taken
    repeat (3) begin
      @(posedge mclk);
      setup_token <= 1'b0;
      #1;
      seen |= ep_reinit[1];
    end
    check({seen, ep_stalled}, 8'h40);
    $display("test stall done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {mclk, bus_reset, ev_valid, ev_success, ev_setup, ev_data1, setup_token} = 7'h00;
    {ev_ep, ev_error, buf_full} = 13'h0000;
    srst = 1'b1;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    #1;
    t_addr();
    t_mode();
    t_events();
    t_select();
    t_stall();
    end_of_test();
  end

  // far longer than the roughly six hundred and forty cycles the tests take
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule
